/* dfmrc_top.sv */
module dfmrc_top
  import dfmrc_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire logic                core_system_clock_enable,
  input  wire logic [NUM_DSP-1:0]  dma_buffer_full,
  input  wire logic                second_interrupt_status,
  input  wire logic [NUM_DSP-1:0]  peer_start,
  input  wire logic [NUM_DSP-1:0]  core_shared_we,
  input  wire logic [$clog2(DEPTH)-1:0] core_shared_addr0,
  input  wire logic [$clog2(DEPTH)-1:0] core_shared_addr1,
  input  wire logic [DM_WIDTH-1:0] core_shared_wdata0,
  input  wire logic [DM_WIDTH-1:0] core_shared_wdata1,
  output logic [NUM_DSP-1:0]       dsp_clock_tick,
  output logic [NUM_DSP-1:0]       firmware_memory_ready,
  output logic [NUM_DSP-1:0]       mem_ready_event,
  output logic [NUM_DSP-1:0]       core_running,
  output logic [NUM_DSP-1:0]       dsp_start_pulse,
  output logic                     collision_event
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || DEPTH * PM_CHUNKS > 64) begin : g_bad_depth
    $error("dfmrc_top: DEPTH out of range");
  end

  // =============================================================
  // State
  typedef struct packed {
    logic                                    awrdy, wrdy, arrdy;
    logic                                    awv, wv, bv, rv;
    logic [ADDR_W-1:0]                       awa;
    logic [31:0]                             wd;
    logic [3:0]                              ws;
    logic [1:0]                              br, rr;
    logic [31:0]                             rd;
    logic [NUM_DSP-1:0]                      clk_en, core_en, retain, ready;
    logic [NUM_DSP-1:0]                      run, start_p, ready_ev;
    logic [NUM_DSP-1:0][RATE_W-1:0]          rate;
    logic [NUM_DSP-1:0][TRIG_W-1:0]          trig;
    logic                                    irq_prev;
    logic [3*CHUNK_W-1:0]                    stage;
    logic [AW-1:0]                           coll_addr;
    logic                                    coll_flag, coll_ev;
    logic [NUM_DSP-1:0][DEPTH-1:0]           pm_vld, dm_vld;
    logic [DEPTH-1:0]                        sh_vld;
    logic [NUM_DSP-1:0][DEPTH-1:0][PM_WIDTH-1:0] pm;
    logic [NUM_DSP-1:0][DEPTH-1:0][DM_WIDTH-1:0] dm;
    logic [DEPTH-1:0][DM_WIDTH-1:0]          sh;
  } dfmrc_state_type;

  typedef struct packed {
    logic       mapped, is_mem, is_pm, is_sh, dsp, last;
    logic [5:0] word;
    logic [1:0] chunk;
  } dfmrc_dec_type;

  dfmrc_state_type                st_q;
  dfmrc_state_type                st_d;
  logic [NUM_DSP-1:0][RATE_W-1:0] rate_rb;
  logic [NUM_DSP-1:0]             clk_on;
  logic [NUM_DSP-1:0]             acc;
  logic                           mem_rd_blocked;

  // =============================================================
  // Helpers
  function automatic dfmrc_dec_type decode(input logic [ADDR_W-1:0] a);
    dfmrc_dec_type d;
    logic [3:0]    win;
    logic [5:0]    idx;
    d   = '0;
    win = a[11:8];
    idx = a[7:2];
    d.is_pm  = (win == WIN_PM0) || (win == WIN_PM1);
    d.is_sh  = (win == WIN_SHA) || (win == WIN_SHB);
    d.is_mem = d.is_pm || d.is_sh || (win == WIN_DM0) || (win == WIN_DM1);
    d.dsp    = (win == WIN_PM1) || (win == WIN_DM1);
    d.word   = d.is_pm ? idx / 6'd3 : {1'b0, idx[5:1]};
    d.chunk  = d.is_pm ? 2'(idx - 6'(d.word * 6'd3)) : {1'b0, idx[0]};
    d.last   = d.chunk == (d.is_pm ? 2'(PM_CHUNKS - 1) : 2'(DM_CHUNKS - 1));
    if (d.is_mem) begin
      d.mapped = a[1:0] == 2'b00 && d.word < 6'(DEPTH);
    end else begin
      d.mapped = win == WIN_CTRL && (a[7:0] == OFS_CTRL0 || a[7:0] == OFS_STAT0
               || a[7:0] == OFS_CTRL1 || a[7:0] == OFS_STAT1 || a[7:0] == OFS_COLL);
    end
    return d;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = v[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic [31:0] ctrl_image(input dfmrc_state_type s, input int n);
    logic [31:0] r;
    r = '0;
    r[CTL_CLK_EN_BIT]               = s.clk_en[n];
    r[CTL_CORE_EN_BIT]              = s.core_en[n];
    r[CTL_RETAIN_BIT]               = s.retain[n];
    r[CTL_RATE_LSB +: RATE_W]       = s.rate[n];
    r[CTL_TRIG_LSB +: TRIG_W]       = s.trig[n];
    return r;
  endfunction

  // =============================================================
  // DSP clock dividers and access conditions
  for (genvar g = 0; g < NUM_DSP; g++) begin : g_div
    assign clk_on[g] = st_q.clk_en[g] && core_system_clock_enable;
    assign acc[g]    = st_q.ready[g] && clk_on[g] && !st_q.core_en[g];
    dfmrc_clkdiv #(.SEL_W(RATE_W)) u_div (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .run           (clk_on[g]),
      .div_sel       (st_q.rate[g]),
      .tick          (dsp_clock_tick[g]),
      .rate_readback (rate_rb[g])
    );
  end

  // =============================================================
  // Next state
  always_comb begin
    dfmrc_dec_type        dw, dr;
    logic [31:0]          cv;
    logic [3*CHUNK_W-1:0] word48;
    logic                 ok, trig_hit;
    int                   n_chunks, sel;
    st_d           = st_q;
    dw             = decode(st_q.awa);
    dr             = decode(araddr);
    cv             = '0;
    word48         = '0;
    ok             = 1'b0;
    trig_hit       = 1'b0;
    n_chunks       = 0;
    sel            = 0;
    mem_rd_blocked = 1'b0;
    st_d.start_p   = '0;
    st_d.ready_ev  = '0;
    st_d.coll_ev   = 1'b0;
    st_d.irq_prev  = second_interrupt_status;
    // Bus address and data capture
    if (awvalid && st_q.awrdy) begin
      st_d.awv = 1'b1;
      st_d.awa = awaddr;
    end
    if (wvalid && st_q.wrdy) begin
      st_d.wv = 1'b1;
      st_d.wd = wdata;
      st_d.ws = wstrb;
    end
    if (bready && st_q.bv) st_d.bv = 1'b0;
    if (rready && st_q.rv) st_d.rv = 1'b0;
    // Ready flags, events and core run control
    for (int d = 0; d < NUM_DSP; d++) begin
      st_d.ready[d]    = clk_on[d];
      st_d.ready_ev[d] = clk_on[d] && !st_q.ready[d];
      if (!st_q.retain[d] && !st_q.clk_en[d]) begin
        st_d.pm_vld[d] = '0;
        st_d.dm_vld[d] = '0;
        st_d.sh_vld    = '0;
      end
      unique case (dfmrc_trig_type'(st_q.trig[d]))
        TRIG_START_BIT: trig_hit = 1'b0;
        TRIG_DMA:       trig_hit = dma_buffer_full[d];
        TRIG_IRQ:       trig_hit = second_interrupt_status && !st_q.irq_prev;
        TRIG_PEER:      trig_hit = peer_start[d];
      endcase
      if (!st_q.core_en[d] || !clk_on[d]) begin
        st_d.run[d] = 1'b0;
      end else if (trig_hit && !st_q.run[d]) begin
        st_d.run[d]     = 1'b1;
        st_d.start_p[d] = 1'b1;
      end
    end
    // Core writes to the shared area, first core wins a clash
    if (core_shared_we[1]) st_d.sh[core_shared_addr1] = core_shared_wdata1;
    if (core_shared_we[0]) st_d.sh[core_shared_addr0] = core_shared_wdata0;
    if (core_shared_we[1]) st_d.sh_vld[core_shared_addr1] = 1'b1;
    if (core_shared_we[0]) st_d.sh_vld[core_shared_addr0] = 1'b1;
    // Register write, once address, data and a free response slot meet
    if (st_q.awv && st_q.wv && !st_q.bv) begin
      st_d.awv = 1'b0;
      st_d.wv  = 1'b0;
      st_d.bv  = 1'b1;
      st_d.br  = dw.mapped ? RESP_OKAY : RESP_SLVERR;
      ok       = dw.is_sh ? |acc : acc[dw.dsp];
      n_chunks = dw.is_pm ? PM_CHUNKS : DM_CHUNKS;
      if (dw.mapped && dw.is_mem && ok && st_q.ws[1:0] == 2'b11) begin
        if (!dw.last) begin
          st_d.stage[(n_chunks - 1 - int'(dw.chunk)) * CHUNK_W +: CHUNK_W] = st_q.wd[15:0];
        end else begin
          word48 = {st_q.stage[3*CHUNK_W-1:CHUNK_W], st_q.wd[15:0]};
          if (dw.is_pm) begin
            st_d.pm[dw.dsp][dw.word[AW-1:0]]     = word48[PM_WIDTH-1:0];
            st_d.pm_vld[dw.dsp][dw.word[AW-1:0]] = 1'b1;
          end else if (dw.is_sh) begin
            st_d.sh[dw.word[AW-1:0]]     = word48[DM_WIDTH-1:0];
            st_d.sh_vld[dw.word[AW-1:0]] = 1'b1;
          end else begin
            st_d.dm[dw.dsp][dw.word[AW-1:0]]     = word48[DM_WIDTH-1:0];
            st_d.dm_vld[dw.dsp][dw.word[AW-1:0]] = 1'b1;
          end
        end
      end else if (dw.mapped && !dw.is_mem) begin
        sel = (st_q.awa[7:0] == OFS_CTRL1) ? 1 : 0;
        if (st_q.awa[7:0] == OFS_CTRL0 || st_q.awa[7:0] == OFS_CTRL1) begin
          cv = merge(ctrl_image(st_q, sel), st_q.wd, st_q.ws);
          st_d.clk_en[sel]  = cv[CTL_CLK_EN_BIT];
          st_d.core_en[sel] = cv[CTL_CORE_EN_BIT];
          st_d.retain[sel]  = cv[CTL_RETAIN_BIT];
          st_d.rate[sel]    = cv[CTL_RATE_LSB +: RATE_W];
          st_d.trig[sel]    = cv[CTL_TRIG_LSB +: TRIG_W];
          if (cv[CTL_START_BIT] && st_q.core_en[sel] && clk_on[sel] && !st_q.run[sel]) begin
            st_d.run[sel]     = 1'b1;
            st_d.start_p[sel] = 1'b1;
          end
        end else if (st_q.awa[7:0] == OFS_COLL && st_q.ws[2] && st_q.wd[COLL_FLAG_BIT]) begin
          st_d.coll_flag = 1'b0;
        end
      end
    end
    // Collision capture after any clear, so a new clash is kept
    if (&core_shared_we && core_shared_addr0 == core_shared_addr1) begin
      st_d.coll_addr = core_shared_addr0;
      st_d.coll_flag = 1'b1;
      st_d.coll_ev   = 1'b1;
    end
    // Register read, answered one cycle after the address is taken
    if (arvalid && st_q.arrdy) begin
      st_d.rv  = 1'b1;
      st_d.rr  = dr.mapped ? RESP_OKAY : RESP_SLVERR;
      st_d.rd  = '0;
      ok       = dr.is_sh ? |acc : acc[dr.dsp];
      n_chunks = dr.is_pm ? PM_CHUNKS : DM_CHUNKS;
      if (dr.mapped && dr.is_mem) begin
        mem_rd_blocked = !ok;
        if (ok) begin
          if (dr.is_pm && st_q.pm_vld[dr.dsp][dr.word[AW-1:0]]) begin
            word48 = 48'(st_q.pm[dr.dsp][dr.word[AW-1:0]]);
          end else if (dr.is_sh && st_q.sh_vld[dr.word[AW-1:0]]) begin
            word48 = 48'(st_q.sh[dr.word[AW-1:0]]);
          end else if (!dr.is_pm && !dr.is_sh && st_q.dm_vld[dr.dsp][dr.word[AW-1:0]]) begin
            word48 = 48'(st_q.dm[dr.dsp][dr.word[AW-1:0]]);
          end
          word48 = word48 >> ((n_chunks - 1 - int'(dr.chunk)) * CHUNK_W);
          st_d.rd = {16'h0000, word48[CHUNK_W-1:0]};
        end
      end else if (dr.mapped) begin
        sel = (araddr[7:0] == OFS_CTRL1 || araddr[7:0] == OFS_STAT1) ? 1 : 0;
        if (araddr[7:0] == OFS_CTRL0 || araddr[7:0] == OFS_CTRL1) begin
          st_d.rd = ctrl_image(st_q, sel);
        end else if (araddr[7:0] == OFS_COLL) begin
          st_d.rd[AW-1:0]          = st_q.coll_addr;
          st_d.rd[COLL_FLAG_BIT]   = st_q.coll_flag;
        end else begin
          st_d.rd[STS_READY_BIT]           = st_q.ready[sel];
          st_d.rd[STS_RUN_BIT]             = st_q.run[sel];
          st_d.rd[STS_RATE_LSB +: RATE_W]  = rate_rb[sel];
        end
      end
    end
    st_d.awrdy = !st_d.awv;
    st_d.wrdy  = !st_d.wv;
    st_d.arrdy = !st_d.rv;
    // Synchronous reset; memory words survive unless retention is off
    if (!aresetn) begin
      st_d         = '0;
      st_d.pm      = st_q.pm;
      st_d.dm      = st_q.dm;
      st_d.sh      = st_q.sh;
      st_d.clk_en  = {NUM_DSP{RST_CLK_EN}};
      st_d.core_en = {NUM_DSP{RST_CORE_EN}};
      st_d.retain  = {NUM_DSP{RST_RETAIN}};
      st_d.rate    = {NUM_DSP{RST_RATE}};
      st_d.trig    = {NUM_DSP{RST_TRIG}};
      // An unknown retention bit at power-up counts as off
      for (int d = 0; d < NUM_DSP; d++) begin
        if (st_q.retain[d]) begin
          st_d.pm_vld[d] = st_q.pm_vld[d];
          st_d.dm_vld[d] = st_q.dm_vld[d];
        end
      end
      if (&st_q.retain) begin
        st_d.sh_vld = st_q.sh_vld;
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    st_q <= st_d;
  end

  // Outputs straight from the state register
  assign awready               = st_q.awrdy;
  assign wready                = st_q.wrdy;
  assign arready               = st_q.arrdy;
  assign bvalid                = st_q.bv;
  assign bresp                 = st_q.br;
  assign rvalid                = st_q.rv;
  assign rresp                 = st_q.rr;
  assign rdata                 = st_q.rd;
  assign firmware_memory_ready = st_q.ready;
  assign mem_ready_event       = st_q.ready_ev;
  assign core_running          = st_q.run;
  assign dsp_start_pulse       = st_q.start_p;
  assign collision_event       = st_q.coll_ev;

  // =============================================================
  // Checks
  sequence s_write_pair;
    st_q.awv && st_q.wv && !st_q.bv;
  endsequence
  sequence s_clash;
    &core_shared_we && core_shared_addr0 == core_shared_addr1;
  endsequence

  property p_write_resp;
    @(posedge aclk) disable iff (!aresetn) s_write_pair |=> bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response missing");

  property p_ready_flag;
    @(posedge aclk) disable iff (!aresetn) clk_on[0] |=> firmware_memory_ready[0];
  endproperty
  a_ready_flag: assert property (p_ready_flag) else $error("ready flag not set");

  property p_no_clock_no_ready;
    @(posedge aclk) disable iff (!aresetn)
      !st_q.clk_en[0] |=> !firmware_memory_ready[0] && !acc[0];
  endproperty
  a_no_clock_no_ready: assert property (p_no_clock_no_ready) else $error("access without clock");

  property p_collision;
    logic [AW-1:0] a;
    @(posedge aclk) disable iff (!aresetn)
      (s_clash, a = core_shared_addr0) |=> collision_event && st_q.coll_addr == a;
  endproperty
  a_collision: assert property (p_collision) else $error("collision not captured");

  property p_blocked_read;
    @(posedge aclk) disable iff (!aresetn) mem_rd_blocked |=> rvalid && rdata == 32'h0000_0000;
  endproperty
  a_blocked_read: assert property (p_blocked_read) else $error("blocked read not zero");

  property p_start_needs_core;
    @(posedge aclk) disable iff (!aresetn)
      dsp_start_pulse[1] |-> $past(st_q.core_en[1]) && core_running[1];
  endproperty
  a_start_needs_core: assert property (p_start_needs_core) else $error("start while disabled");

  property p_stop_on_disable;
    @(posedge aclk) disable iff (!aresetn) !st_q.core_en[0] |=> !core_running[0];
  endproperty
  a_stop_on_disable: assert property (p_stop_on_disable) else $error("core kept running");

  property p_dma_start;
    @(posedge aclk) disable iff (!aresetn)
      st_q.core_en[1] && clk_on[1] && !st_q.run[1] && st_q.trig[1] == TRIG_DMA
      && dma_buffer_full[1] |=> dsp_start_pulse[1] ##1 core_running[1];
  endproperty
  a_dma_start: assert property (p_dma_start) else $error("DMA start missed");

  property p_wipe;
    @(posedge aclk) disable iff (!aresetn)
      !st_q.retain[0] && !st_q.clk_en[0] |=> st_q.pm_vld[0] == '0 && st_q.dm_vld[0] == '0;
  endproperty
  a_wipe: assert property (p_wipe) else $error("memory not dropped");

  property p_retain;
    @(posedge aclk) disable iff (!aresetn)
      st_q.retain[1] && !st_q.clk_en[1] |=> $stable(st_q.pm_vld[1]);
  endproperty
  a_retain: assert property (p_retain) else $error("memory lost with retention");
endmodule // dfmrc_top

/* dfmrc_pkg.sv */
// =============================================================
// Shared constants for the DSP firmware memory and run control
package dfmrc_pkg;
  localparam int NUM_DSP   = 2;   // Two DSP blocks, sharing one data area
  localparam int PM_WIDTH  = 40;  // Program word width
  localparam int DM_WIDTH  = 24;  // Coefficient and data word width
  localparam int CHUNK_W   = 16;  // Register location width
  localparam int PM_CHUNKS = 3;   // Locations per program word
  localparam int DM_CHUNKS = 2;   // Locations per data word
  localparam int MEM_DEPTH = 16;  // Words per memory area
  localparam int ADDR_W    = 12;  // Byte address width on the bus
  localparam int RATE_W    = 3;   // Clock rate select width
  localparam int TRIG_W    = 2;   // Trigger source select width

  // =============================================================
  // Address windows, selected by address bits 11:8
  localparam logic [3:0] WIN_CTRL = 4'h0;
  localparam logic [3:0] WIN_PM0  = 4'h1;
  localparam logic [3:0] WIN_DM0  = 4'h2;
  localparam logic [3:0] WIN_PM1  = 4'h3;
  localparam logic [3:0] WIN_DM1  = 4'h4;
  localparam logic [3:0] WIN_SHA  = 4'h5;
  localparam logic [3:0] WIN_SHB  = 4'h6;

  // Control window offsets, address bits 7:0
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_STAT0 = 8'h04;
  localparam logic [7:0] OFS_CTRL1 = 8'h08;
  localparam logic [7:0] OFS_STAT1 = 8'h0C;
  localparam logic [7:0] OFS_COLL  = 8'h10;

  // =============================================================
  // Field positions
  localparam int CTL_CLK_EN_BIT  = 0;
  localparam int CTL_CORE_EN_BIT = 1;
  localparam int CTL_RETAIN_BIT  = 2;
  localparam int CTL_START_BIT   = 3;
  localparam int CTL_RATE_LSB    = 4;
  localparam int CTL_TRIG_LSB    = 8;
  localparam int STS_READY_BIT   = 0;
  localparam int STS_RUN_BIT     = 1;
  localparam int STS_RATE_LSB    = 4;
  localparam int COLL_FLAG_BIT   = 16;

  // Reset values
  localparam logic              RST_CLK_EN  = 1'b0;
  localparam logic              RST_CORE_EN = 1'b0;
  localparam logic              RST_RETAIN  = 1'b1;
  localparam logic [RATE_W-1:0] RST_RATE    = 3'h0;
  localparam logic [TRIG_W-1:0] RST_TRIG    = 2'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Execution start sources
  typedef enum logic [TRIG_W-1:0] {
    TRIG_START_BIT,
    TRIG_DMA,
    TRIG_IRQ,
    TRIG_PEER
  } dfmrc_trig_type;
endpackage

/* dfmrc_clkdiv.sv */
// =============================================================
// DSP clock strobe derived from the system clock by integer division
module dfmrc_clkdiv
  import dfmrc_pkg::*;
#(
  parameter int SEL_W = RATE_W
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             run,
  input  wire logic [SEL_W-1:0] div_sel,
  output logic                  tick,
  output logic [SEL_W-1:0]      rate_readback
);
  if (SEL_W < 1 || SEL_W > 8) begin : g_bad_width
    $error("dfmrc_clkdiv: SEL_W out of range");
  end

  typedef struct packed {
    logic [SEL_W-1:0] cnt;
    logic             tick;
    logic [SEL_W-1:0] rate;
  } dfmrc_div_type;

  dfmrc_div_type st_q;
  dfmrc_div_type st_d;

  // Divide by select plus one; never faster than the system clock
  always_comb begin
    st_d = st_q;
    if (!aresetn || !run) begin
      st_d = '0;
    end else begin
      st_d.rate = div_sel;
      if (st_q.cnt >= div_sel) begin
        st_d.cnt  = '0;
        st_d.tick = 1'b1;
      end else begin
        st_d.cnt  = st_q.cnt + 1'b1;
        st_d.tick = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    st_q <= st_d;
  end

  assign tick          = st_q.tick;
  assign rate_readback = st_q.rate;
endmodule // dfmrc_clkdiv

/* dfmrc_host.sv */
// =============================================================
// Host model: register bus master loading the firmware
module dfmrc_host
  import dfmrc_pkg::*;
(
  input  wire logic         aclk,
  output logic [ADDR_W-1:0] awaddr,
  output logic              awvalid,
  input  wire logic         awready,
  output logic [31:0]       wdata,
  output logic [3:0]        wstrb,
  output logic              wvalid,
  input  wire logic         wready,
  input  wire logic [1:0]   bresp,
  input  wire logic         bvalid,
  output logic              bready,
  output logic [ADDR_W-1:0] araddr,
  output logic              arvalid,
  input  wire logic         arready,
  input  wire logic [31:0]  rdata,
  input  wire logic [1:0]   rresp,
  input  wire logic         rvalid,
  output logic              rready,
  output logic              hung
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready, hung} = '0;
  end
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
    int i;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, v, 4'hF};
    {awvalid, wvalid, bready} <= 3'b111;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    r = bresp;
    if (i == 100) hung <= 1'b1;
  endtask
  // Read: address released when taken, rready held until rvalid is sampled
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    {d, r} = {rdata, rresp};
    if (i == 100) hung <= 1'b1;
  endtask
endmodule // dfmrc_host

/* dsp_firmware_memory_and_run_control_test.sv */
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch at %0t: %h vs %h", $time, a, b); end end
// =============================================================
// Bench for firmware memory and run control
module dsp_firmware_memory_and_run_control_test
  import dfmrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, core_system_clock_enable, second_interrupt_status, collision_event;
  logic hung;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, core_shared_addr0, core_shared_addr1;
  logic [1:0] bresp, rresp, r, dma_buffer_full, peer_start, core_shared_we, dsp_clock_tick;
  logic [1:0] firmware_memory_ready, mem_ready_event, core_running, dsp_start_pulse;
  logic [DM_WIDTH-1:0] core_shared_wdata0, core_shared_wdata1;
  int fail_count, n_compared;
  dfmrc_top u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .core_system_clock_enable, .dma_buffer_full, .second_interrupt_status,
    .peer_start, .core_shared_we, .core_shared_addr0, .core_shared_addr1, .core_shared_wdata0,
    .core_shared_wdata1, .dsp_clock_tick, .firmware_memory_ready, .mem_ready_event,
    .core_running, .dsp_start_pulse, .collision_event);
  dfmrc_host u_host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .hung);
  // Clock at 125 MHz
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    u_host.rd(a, d, r);
    `CHK(d, e)
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    u_host.wr(a, v, r);
    `CHK(r, RESP_OKAY)
  endtask
  // Clocks on, words of every kind loaded and read back
  task automatic s_load;
    core_system_clock_enable <= 1'b1;
    wr(12'h000, 32'h0000_0005);
    wr(12'h008, 32'h0000_0015);
    #1 `CHK(mem_ready_event, 2'b10)
    repeat (2) @(posedge aclk);
    `CHK(firmware_memory_ready, 2'b11)
    #1 d[0] = dsp_clock_tick[1];
    @(posedge aclk);
    #1 `CHK(dsp_clock_tick, {~d[0], 1'b1})
    rc(12'h00C, 32'h0000_0011);
    wr(12'h100, 32'h0000_0012);
    wr(12'h104, 32'h0000_3456);
    wr(12'h108, 32'h0000_789A);
    rc(12'h100, 32'h0000_0012);
    rc(12'h108, 32'h0000_789A);
    wr(12'h200, 32'h0000_00AB);
    wr(12'h204, 32'h0000_CDEF);
    rc(12'h200, 32'h0000_00AB);
    wr(12'h404, 32'h0000_0F0F);
    wr(12'h504, 32'h0000_2233);
    rc(12'h604, 32'h0000_2233);
    u_host.rd(12'h700, d, r);
    `CHK(r, RESP_SLVERR)
  endtask
  // Both cores write shared word 5 in one cycle
  task automatic s_coll;
    {core_shared_addr0, core_shared_addr1, core_shared_we} <= {4'h5, 4'h5, 2'b11};
    {core_shared_wdata0, core_shared_wdata1} <= {24'h12_3456, 24'h65_4321};
    @(posedge aclk);
    core_shared_we <= 2'b00;
    #1 `CHK(collision_event, 1'b1)
    rc(12'h010, 32'h0001_0005);
    rc(12'h62C, 32'h0000_3456);
  endtask
  // Blocked access with the core enabled; DMA, start bit, interrupt and peer triggers
  task automatic s_run;
    wr(12'h008, 32'h0000_0117);
    wr(12'h404, 32'h0000_5555);
    rc(12'h404, 32'h0000_0000);
    dma_buffer_full <= 2'b10;
    @(posedge aclk);
    dma_buffer_full <= 2'b00;
    #1 `CHK(dsp_start_pulse, 2'b10)
    @(posedge aclk);
    #1 `CHK(core_running, 2'b10)
    wr(12'h000, 32'h0000_0007);
    wr(12'h000, 32'h0000_000F);
    @(posedge aclk);
    #1 `CHK(core_running, 2'b11)
    wr(12'h000, 32'h0000_0205);
    #1 `CHK(core_running, 2'b10)
    wr(12'h000, 32'h0000_0207);
    second_interrupt_status <= 1'b1;
    repeat (2) @(posedge aclk);
    #1 `CHK(core_running, 2'b11)
    wr(12'h000, 32'h0000_0305);
    #1 `CHK(core_running, 2'b10)
    wr(12'h000, 32'h0000_0307);
    peer_start <= 2'b01;
    @(posedge aclk);
    peer_start <= 2'b00;
    @(posedge aclk);
    #1 `CHK(core_running, 2'b11)
  endtask
  // Clock off with and without retention
  task automatic s_retain;
    wr(12'h008, 32'h0000_0014);
    wr(12'h008, 32'h0000_0004);
    wr(12'h008, 32'h0000_0015);
    wr(12'h000, 32'h0000_0001);
    wr(12'h000, 32'h0000_0000);
    wr(12'h000, 32'h0000_0005);
    repeat (2) @(posedge aclk);
    rc(12'h404, 32'h0000_0F0F);
    rc(12'h200, 32'h0000_0000);
    rc(12'h604, 32'h0000_0000);
    // Reset in mid-run keeps retained words
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(12'h008, 32'h0000_0004);
    wr(12'h008, 32'h0000_0005);
    rc(12'h404, 32'h0000_0F0F);
  endtask
  // Reset, then the scenarios
  initial begin
    {aresetn, core_system_clock_enable, second_interrupt_status} = 3'b000;
    {dma_buffer_full, peer_start, core_shared_we, core_shared_addr0, core_shared_addr1} = '0;
    {core_shared_wdata0, core_shared_wdata1, fail_count, n_compared} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    s_load;
    s_coll;
    s_run;
    s_retain;
    stop_test;
  end
  // A bus wait that ran out ends the run
  always @(posedge hung) begin
    fail_count++;
    stop_test;
  end
endmodule // dsp_firmware_memory_and_run_control_test
